/* File: design/sdcbd_bank.sv */
// sdcbd_bank: open or idle state of one bank
// assumes: activate and precharge strobes already qualified per bank
`timescale 1ns/1ps
module sdcbd_bank
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// per-bank strobes
	input  wire logic open_req,
	input  wire logic close_req,
	// state
	output logic      is_open
);

	// ************************************************************
	// bank state
	// ************************************************************
	// activate and precharge never hit the same bank in one cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			is_open <= 1'b0;
		else if (open_req)
			is_open <= 1'b1;
		else if (close_req)
			is_open <= 1'b0;
	end

endmodule

/* File: design/sdcbd_pkg.sv */
// sdcbd_pkg: shared constants and types for the command bank decoder
// assumes: compiled before every design file of the block
package sdcbd_pkg;

	// ************************************************************
	// widths and field positions
	// ************************************************************
	localparam int NUM_BANKS      = 4;
	localparam int BANK_BITS      = 2;
	localparam int ADDR_BITS      = 12;
	localparam int COL_LSB        = 0;
	localparam int COL_MSB        = 7;
	localparam int COL_BITS       = COL_MSB - COL_LSB + 1;
	localparam int AUTO_PRE_BIT   = 10;
	localparam int CMD_NOP_CYCLES = 1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [3:0]  BANK_OPEN_RST = 4'h0;
	localparam logic [11:0] ADDR_RST      = 12'h000;
	localparam logic [1:0]  BANK_RST      = 2'h0;

	// ************************************************************
	// decoded command codes, one-hot
	// ************************************************************
	typedef enum logic [6:0] {
		SDCBD_CMD_DESEL = 7'h01,
		SDCBD_CMD_NOP   = 7'h02,
		SDCBD_CMD_ACT   = 7'h04,
		SDCBD_CMD_PRE   = 7'h08,
		SDCBD_CMD_READ  = 7'h10,
		SDCBD_CMD_WRITE = 7'h20,
		SDCBD_CMD_OTHER = 7'h40
	} sdcbd_cmd_t;

endpackage

/* File: design/sdcbd_top.sv */
// sdcbd_top: command pin decoder and bank state tracker
// assumes: all pins but RST_N synchronous to REF_CLK, driven by the controller
`timescale 1ns/1ps
module sdcbd_top
#(
	parameter int NUM_BANKS = sdcbd_pkg::NUM_BANKS,
	parameter int ADDR_BITS = sdcbd_pkg::ADDR_BITS
)
(
	// clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RST_N,
	// command pins
	input  wire logic                 CHIP_SEL_N,
	input  wire logic                 ROW_STROBE_N,
	input  wire logic                 COL_STROBE_N,
	input  wire logic                 WRITE_STROBE_N,
	// bank and address pins
	input  wire logic                 BANK_SELECT_LO,
	input  wire logic                 BANK_SELECT_HI,
	input  wire logic [ADDR_BITS-1:0] ADDRESS_BUS,
	// decoded command, registered on the sampling edge
	output logic                      CMD_VALID,
	output logic [6:0]                CMD_CODE,
	output logic [1:0]                CMD_BANK,
	output logic [ADDR_BITS-1:0]      ROW_ADDR,
	output logic [7:0]                COL_ADDR,
	output logic                      AUTO_PRECHARGE_FLAG,
	output logic                      PRECHARGE_ALL,
	// bank state
	output logic [NUM_BANKS-1:0]      BANK_OPEN
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_meta_r;
	logic rst_n_r;

	// asynchronous assert, release through two flops
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ************************************************************
	// combinational decode of the sampled pins
	// ************************************************************
	logic [1:0]                  bank_sel;
	sdcbd_pkg::sdcbd_cmd_t       cmd_nxt;
	logic [NUM_BANKS-1:0]        open_req;
	logic [NUM_BANKS-1:0]        close_req;
	logic                        auto_pre;

	assign bank_sel = {BANK_SELECT_HI, BANK_SELECT_LO};
	assign auto_pre = ADDRESS_BUS[sdcbd_pkg::AUTO_PRE_BIT];

	// truth table of the strobes; deselect masks everything
	always_comb
	begin
		cmd_nxt = sdcbd_pkg::SDCBD_CMD_OTHER;
		if (CHIP_SEL_N)
			cmd_nxt = sdcbd_pkg::SDCBD_CMD_DESEL;
		else
		begin
			case ({ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N})
				3'h3:    cmd_nxt = sdcbd_pkg::SDCBD_CMD_ACT;
				3'h2:    cmd_nxt = sdcbd_pkg::SDCBD_CMD_PRE;
				3'h5:    cmd_nxt = sdcbd_pkg::SDCBD_CMD_READ;
				3'h4:    cmd_nxt = sdcbd_pkg::SDCBD_CMD_WRITE;
				3'h7:    cmd_nxt = sdcbd_pkg::SDCBD_CMD_NOP;
				default: cmd_nxt = sdcbd_pkg::SDCBD_CMD_OTHER;
			endcase
		end
	end

	// per-bank strobes; precharge with bit 10 high closes every bank
	always_comb
	begin
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			open_req[i]  = (cmd_nxt == sdcbd_pkg::SDCBD_CMD_ACT) &&
				(bank_sel == i[1:0]);
			close_req[i] = (cmd_nxt == sdcbd_pkg::SDCBD_CMD_PRE) &&
				(auto_pre || (bank_sel == i[1:0]));
		end
	end

	// ************************************************************
	// registered command outputs
	// ************************************************************
	// every field latched on each rising edge, so outputs lag pins by one
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			CMD_VALID           <= 1'b0;
			CMD_CODE            <= sdcbd_pkg::SDCBD_CMD_DESEL;
			CMD_BANK            <= sdcbd_pkg::BANK_RST;
			ROW_ADDR            <= sdcbd_pkg::ADDR_RST;
			COL_ADDR            <= sdcbd_pkg::ADDR_RST[sdcbd_pkg::COL_MSB:sdcbd_pkg::COL_LSB];
			AUTO_PRECHARGE_FLAG <= 1'b0;
			PRECHARGE_ALL       <= 1'b0;
		end
		else
		begin
			CMD_VALID <= !CHIP_SEL_N;
			CMD_CODE  <= cmd_nxt;
			CMD_BANK  <= bank_sel;
			ROW_ADDR  <= ADDRESS_BUS;
			COL_ADDR  <= ADDRESS_BUS[sdcbd_pkg::COL_MSB:sdcbd_pkg::COL_LSB];
			AUTO_PRECHARGE_FLAG <= auto_pre && ((cmd_nxt == sdcbd_pkg::SDCBD_CMD_READ) ||
				(cmd_nxt == sdcbd_pkg::SDCBD_CMD_WRITE));
			PRECHARGE_ALL <= auto_pre && (cmd_nxt == sdcbd_pkg::SDCBD_CMD_PRE);
		end
	end

	// ************************************************************
	// bank state, one tracker per bank
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++)
		begin : g_bank
			sdcbd_bank u_bank
			(
				.clk       (REF_CLK),
				.rst_n     (rst_n_r),
				.open_req  (open_req[g]),
				.close_req (close_req[g]),
				.is_open   (BANK_OPEN[g])
			);
		end
	endgenerate

	// ************************************************************
	// assertions
	// ************************************************************
	// checks start one edge after the internal reset lifts: the edge that
	// lifts it still holds the outputs, so pins seen there are not decoded
	logic chk_en_r;

	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			chk_en_r <= 1'b0;
		else
			chk_en_r <= 1'b1;
	end

	sequence s_act_seen;
		!CHIP_SEL_N && !ROW_STROBE_N && COL_STROBE_N && WRITE_STROBE_N;
	endsequence

	sequence s_pre_one;
		!CHIP_SEL_N && !ROW_STROBE_N && COL_STROBE_N && !WRITE_STROBE_N && !auto_pre;
	endsequence

	// row commands: write strobe picks activate or precharge
	sequence s_row_cmd;
		!CHIP_SEL_N && !ROW_STROBE_N && COL_STROBE_N;
	endsequence

	// column access, read or write
	sequence s_col_access;
		!CHIP_SEL_N && ROW_STROBE_N && !COL_STROBE_N;
	endsequence

	a_act_opens_bank: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		s_act_seen |=> BANK_OPEN[$past(bank_sel)] && CMD_CODE == sdcbd_pkg::SDCBD_CMD_ACT)
		else $error("activate did not open bank");

	a_pre_closes_bank: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		s_pre_one |=> !BANK_OPEN[$past(bank_sel)] && !PRECHARGE_ALL)
		else $error("precharge did not close bank");

	a_pre_all_closes: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		(cmd_nxt == sdcbd_pkg::SDCBD_CMD_PRE && auto_pre) |=> BANK_OPEN == '0 && PRECHARGE_ALL)
		else $error("precharge all left a bank open");

	a_desel_masks: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		CHIP_SEL_N |=> !CMD_VALID && $stable(BANK_OPEN))
		else $error("deselected cycle changed state");

	a_nop_keeps_banks: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		(!CHIP_SEL_N && ROW_STROBE_N && COL_STROBE_N && WRITE_STROBE_N)
		|=> $stable(BANK_OPEN) && CMD_CODE == sdcbd_pkg::SDCBD_CMD_NOP)
		else $error("no operation changed bank state");

	a_read_write_split: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		(!CHIP_SEL_N && ROW_STROBE_N && !COL_STROBE_N)
		|=> CMD_CODE == ($past(WRITE_STROBE_N) ? sdcbd_pkg::SDCBD_CMD_READ
			: sdcbd_pkg::SDCBD_CMD_WRITE))
		else $error("read and write swapped");

	a_col_addr_taken: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		(!CHIP_SEL_N && ROW_STROBE_N && !COL_STROBE_N)
		|=> COL_ADDR == $past(ADDRESS_BUS[7:0]) && AUTO_PRECHARGE_FLAG == $past(auto_pre))
		else $error("column address or flag wrong");

	a_bank_field: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		1'b1 |=> CMD_BANK == {$past(BANK_SELECT_HI), $past(BANK_SELECT_LO)})
		else $error("bank select order wrong");

	a_row_we_split: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		s_row_cmd |=> CMD_CODE == ($past(WRITE_STROBE_N) ? sdcbd_pkg::SDCBD_CMD_ACT
			: sdcbd_pkg::SDCBD_CMD_PRE))
		else $error("write strobe did not split activate and precharge");

	// autoprecharge is not timed here, so a column access leaves banks alone
	a_col_keeps_banks: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		s_col_access |=> CMD_VALID && $stable(BANK_OPEN) && !PRECHARGE_ALL)
		else $error("column access changed bank state");

	a_valid_latched: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		!CHIP_SEL_N |=> CMD_VALID && ROW_ADDR == $past(ADDRESS_BUS))
		else $error("selected cycle not latched");

	// mode set, refresh and burst stop are passed on but touch no bank
	a_other_keeps_banks: assert property (@(posedge REF_CLK) disable iff (!chk_en_r)
		(!CHIP_SEL_N && ((!ROW_STROBE_N && !COL_STROBE_N) ||
			(ROW_STROBE_N && COL_STROBE_N && !WRITE_STROBE_N)))
		|=> CMD_CODE == sdcbd_pkg::SDCBD_CMD_OTHER && $stable(BANK_OPEN))
		else $error("other command changed bank state");

endmodule

/* File: verification/sdcbd_ctrl_model.sv */
// sdcbd_ctrl_model: memory controller side, drives every command pin
// assumes: the bench calls drive once per cycle, pins always driven
`timescale 1ns/1ps
module sdcbd_ctrl_model
(
	// clock
	input  wire logic  clk,
	// command pins
	output logic       cs_n,
	output logic       ras_n,
	output logic       cas_n,
	output logic       we_n,
	// bank and address pins
	output logic       bank_lo,
	output logic       bank_hi,
	output logic [11:0] addr
);
	// ************************************************************
	// pin driver
	// ************************************************************
	// idle as deselect until the first command
	initial
	begin
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		{bank_hi, bank_lo} = 2'h0;
		addr = 12'h000;
	end
	// change just after an edge so pins hold steady at the next one
	task automatic drive(input logic [3:0] cmd, input logic [1:0] b, input logic [11:0] a);
		@(posedge clk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = cmd;
		{bank_hi, bank_lo} = b;
		addr = a;
	endtask
endmodule

/* File: verification/sdram_command_bank_decode_test.sv */
// sdram_command_bank_decode_test: queue-scored bench for the decoder
// assumes: one command every cycle once started, latency of one edge
`timescale 1ns/1ps
module sdram_command_bank_decode_test;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cs_n, ras_n, cas_n, we_n, b_lo, b_hi, valid, apf, pall;
	logic [11:0] addr, row;
	logic [6:0]  code;
	logic [1:0]  bank;
	logic [7:0]  col;
	logic [3:0]  open, open_e = 4'h0;
	logic [35:0] notes[$];
	logic [35:0] got;
	logic [31:0] lfsr = 32'h0e5a2bd5;
	int          fail_count = 0;
	int          check_count = 0;
	int          pend;

	always #20 ref_clk = ~ref_clk;

	sdcbd_ctrl_model sdcbd_ctrl_model_i (.clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_lo(b_lo), .bank_hi(b_hi), .addr(addr));
	sdcbd_top sdcbd_top_i (.REF_CLK(ref_clk), .RST_N(rst_n), .CHIP_SEL_N(cs_n),
		.ROW_STROBE_N(ras_n), .COL_STROBE_N(cas_n), .WRITE_STROBE_N(we_n),
		.BANK_SELECT_LO(b_lo), .BANK_SELECT_HI(b_hi), .ADDRESS_BUS(addr),
		.CMD_VALID(valid), .CMD_CODE(code), .CMD_BANK(bank), .ROW_ADDR(row),
		.COL_ADDR(col), .AUTO_PRECHARGE_FLAG(apf), .PRECHARGE_ALL(pall), .BANK_OPEN(open));

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] l);
		return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
	endfunction
	// drive one command and note what the next edge must show
	task automatic issue(input logic [3:0] cmd, input logic [1:0] b, input logic [11:0] a);
		logic [6:0] c;
		c = cmd[3] ? 7'h01 : cmd[2:0] == 3'h3 ? 7'h04 : cmd[2:0] == 3'h2 ? 7'h08
			: cmd[2:0] == 3'h5 ? 7'h10 : cmd[2:0] == 3'h4 ? 7'h20
			: cmd[2:0] == 3'h7 ? 7'h02 : 7'h40;
		if (c == 7'h04)
			open_e[b] = 1'b1;
		if (c == 7'h08)
			open_e = a[10] ? 4'h0 : open_e & ~(4'h1 << b);
		sdcbd_ctrl_model_i.drive(cmd, b, a);
		notes.push_back({~cmd[3], c, b, a, a[7:0], a[10] & (c[4] | c[5]), a[10] & c[3], open_e});
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ************************************************************
	// scoreboard: a note pushed before an edge is due after it
	// ************************************************************
	always @(posedge ref_clk)
	begin
		pend = notes.size();
		#3;
		if (pend > 0)
		begin
			got = {valid, code, bank, row, col, apf, pall, open};
			check_count++;
			if (got !== notes[0])
			begin
				$display("unexpected at %0t: got %h want %h", $time, got, notes[0]);
				fail_count++;
			end
			void'(notes.pop_front());
		end
	end

	// ************************************************************
	// stimulus
	// ************************************************************
	initial
	begin
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int b = 0; b < 4; b++)
			issue(4'h3, b[1:0], 12'h5a0 + 12'(b));
		issue(4'h5, 2'h1, 12'h4a5);
		issue(4'h4, 2'h2, 12'h03c);
		issue(4'h2, 2'h1, 12'h000);
		issue(4'ha, 2'h3, 12'h400);
		issue(4'h7, 2'h0, 12'hfff);
		issue(4'h2, 2'h3, 12'h400);
		issue(4'h0, 2'h0, 12'h000);
		// random pins, half of them deselected
		repeat (300)
		begin
			lfsr = lfsr_next(lfsr);
			issue(lfsr[3:0], lfsr[5:4], lfsr[17:6]);
		end
		// mid-run reset: all outputs and every bank back to reset values
		issue(4'h8, 2'h0, 12'h000);
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b0;
		open_e = 4'h0;
		notes.push_back({1'b0, 7'h01, 28'h0000000});
		@(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		issue(4'h3, 2'h2, 12'h123);
		issue(4'h5, 2'h2, 12'h4ff);
		repeat (3) @(posedge ref_clk);
		test_done();
	end

	// watchdog: the run needs some 330 cycles
	initial
	begin
		#40000;
		fail_count++;
		test_done();
	end
endmodule
